// File: hdl/dsf_top.v
// Summary of operation
// - Reset clears status except ack and tx-empty
// - Received byte loaded sets receive interrupt flag
// - Full receive register blocks further loads
// - Receive flag cleared by zero write or disable
// - Transmit flag set before transmit data load
// - Transmit flag cleared by zero write or disable
// - Own or extended address match sets flag
// - Direction bit updated after calling address
// - One-way mode forces direction one; resets zero
// - Ack bit records receiver ack per byte
// - No ack releases data line for master
// - Clock falling edge sets flag in one-way mode
// - Edge flag cleared by zero, mode, disable
// - Transmit empty cleared on write, set on load
// - Receive full cleared on read, set on load
`timescale 1ns/100ps
`include "dsf_map.vh"
module dsf_top (
	input wire SYS_CLK,
	input wire RST,
	input wire [7:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [3:0] AVS_BYTEENABLE,
	input wire [31:0] AVS_WRITEDATA,
	output wire [31:0] AVS_READDATA,
	output wire AVS_WAITREQUEST,
	output wire IRQ,
	input wire SCL_IN,
	output wire SCL_OUT,
	output wire SCL_OE_N,
	input wire SDA_IN,
	output wire SDA_OUT,
	output wire SDA_OE_N
);
	localparam S_IDLE = 3'h0;
	localparam S_ADDR = 3'h1;
	localparam S_ACK = 3'h2;
	localparam S_RX = 3'h3;
	localparam S_LOAD = 3'h4;
	localparam S_TX = 3'h5;
	localparam S_TXACK = 3'h6;

	function sel;
		input [5:0] idx;
		input [5:0] target;
		begin
			sel = (idx == target);
		end
	endfunction

	wire scl_s;
	wire sda_s;
	wire scl_rise;
	wire scl_fall;
	wire bus_start;
	wire bus_stop;

	dsf_sync #(.W(2)) u_sync (
		.clk(SYS_CLK),
		.rst(RST),
		.din({SCL_IN, SDA_IN}),
		.dout({scl_s, sda_s})
	);

	dsf_cond u_cond (
		.clk(SYS_CLK),
		.rst(RST),
		.scl(scl_s),
		.sda(sda_s),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.bus_start(bus_start),
		.bus_stop(bus_stop)
	);

	// Register bus: every access waits one cycle, then completes.
	reg done_q;
	reg [31:0] rdata_q;
	wire req = AVS_READ | AVS_WRITE;
	wire wr_go = AVS_WRITE & done_q;
	wire rd_go = AVS_READ & done_q;
	wire wr_lo = wr_go & AVS_BYTEENABLE[0];
	wire [5:0] idx = AVS_ADDRESS[7:2];
	wire [7:0] wbyte = AVS_WRITEDATA[7:0];

	assign AVS_WAITREQUEST = req & ~done_q;
	assign AVS_READDATA = rdata_q;

	reg [2:0] ctrl_q;
	reg [6:0] own_addr_q;
	reg [6:0] ext_addr_q;
	reg [7:0] tx_data_reg_q;
	reg [7:0] rx_data_reg_q;
	reg [4:0] irq_st_q;
	reg [4:0] irq_mask_q;

	reg rx_irq_flag_q;
	reg tx_irq_flag_q;
	reg match_q;
	reg slave_dir_flag_q;
	reg ack_seen_n_q;
	reg clk_fall_flag_q;
	reg tx_buf_empty_q;
	reg rx_buf_full_q;

	wire module_on = ctrl_q[`DSF_CTRL_MODULE_ON];
	wire one_way_mode_on = ctrl_q[`DSF_CTRL_ONE_WAY];
	wire ext_addr_on = ctrl_q[`DSF_CTRL_EXT_ADDR];
	wire eng_on = module_on & ~one_way_mode_on;

	wire [7:0] status = {rx_irq_flag_q, tx_irq_flag_q, match_q, slave_dir_flag_q,
		ack_seen_n_q, clk_fall_flag_q, tx_buf_empty_q, rx_buf_full_q};

	wire wr_status = wr_lo & sel(idx, `DSF_IDX_STATUS);
	wire wr_tx_data = wr_lo & sel(idx, `DSF_IDX_TX_DATA);
	wire rd_rx_data = rd_go & sel(idx, `DSF_IDX_RX_DATA);
	wire rd_irq_st = rd_go & sel(idx, `DSF_IDX_IRQ_STATUS);

	always @(posedge SYS_CLK) begin
		if (RST) begin
			done_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			done_q <= req & ~done_q;
			if (AVS_READ & ~done_q) begin
				case (idx)
				`DSF_IDX_CTRL: rdata_q <= {29'h0, ctrl_q};
				`DSF_IDX_OWN_ADDR: rdata_q <= {25'h0, own_addr_q};
				`DSF_IDX_EXT_ADDR: rdata_q <= {25'h0, ext_addr_q};
				`DSF_IDX_STATUS: rdata_q <= {24'h0, status};
				`DSF_IDX_TX_DATA: rdata_q <= {24'h0, tx_data_reg_q};
				`DSF_IDX_RX_DATA: rdata_q <= {24'h0, rx_data_reg_q};
				`DSF_IDX_IRQ_STATUS: rdata_q <= {27'h0, irq_st_q};
				`DSF_IDX_IRQ_MASK: rdata_q <= {27'h0, irq_mask_q};
				default: rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Configuration registers.
	always @(posedge SYS_CLK) begin
		if (RST) begin
			ctrl_q <= `DSF_CTRL_RST;
			own_addr_q <= `DSF_ADDR_RST;
			ext_addr_q <= `DSF_ADDR_RST;
			irq_mask_q <= `DSF_IRQ_RST;
			tx_data_reg_q <= `DSF_TX_DATA_RST;
		end else begin
			if (wr_lo & sel(idx, `DSF_IDX_CTRL))
				ctrl_q <= wbyte[2:0];
			if (wr_lo & sel(idx, `DSF_IDX_OWN_ADDR))
				own_addr_q <= wbyte[6:0];
			if (wr_lo & sel(idx, `DSF_IDX_EXT_ADDR))
				ext_addr_q <= wbyte[6:0];
			if (wr_lo & sel(idx, `DSF_IDX_IRQ_MASK))
				irq_mask_q <= wbyte[4:0];
			if (wr_tx_data)
				tx_data_reg_q <= wbyte;
		end
	end

	// Serial engine state.
	reg [2:0] state_q;
	reg [3:0] cnt_q;
	reg [7:0] sh_q;
	reg ack_on_q;
	reg next_tx_q;
	reg sda_oe_n_q;
	reg scl_oe_n_q;

	wire [7:0] byte_in = {sh_q[6:0], sda_s};
	wire last_bit = scl_rise & (cnt_q == `DSF_BYTE_BITS - 4'h1);
	wire addr_done = eng_on & (state_q == S_ADDR) & last_bit;
	wire addr_ok = addr_done & ((byte_in[7:1] == own_addr_q) |
		(ext_addr_on & (byte_in[7:1] == ext_addr_q)));
	wire rx_done = eng_on & (state_q == S_RX) & last_bit;
	// A byte that arrives while the receive register is still unread is dropped.
	wire rx_load = (addr_ok | rx_done) & ~rx_buf_full_q;
	wire enter_load = eng_on & scl_fall & ~bus_start & ~bus_stop &
		(((state_q == S_ACK) & ack_on_q & next_tx_q) |
		((state_q == S_TXACK) & (cnt_q == `DSF_BYTE_BITS + 4'h1) & ~ack_seen_n_q));
	wire tx_load = eng_on & (state_q == S_LOAD) & ~tx_buf_empty_q;
	wire nack_seen = eng_on & (state_q == S_TXACK) & scl_rise & sda_s;
	wire clk_fall_ev = module_on & one_way_mode_on & scl_fall;

	always @(posedge SYS_CLK) begin
		if (RST | ~eng_on) begin
			state_q <= S_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			ack_on_q <= 1'b0;
			next_tx_q <= 1'b0;
		end else if (bus_start) begin
			state_q <= S_ADDR;
			cnt_q <= 4'h0;
			ack_on_q <= 1'b0;
		end else if (bus_stop) begin
			state_q <= S_IDLE;
			ack_on_q <= 1'b0;
		end else begin
			case (state_q)
			S_ADDR, S_RX: begin
				if (scl_rise) begin
					sh_q <= byte_in;
					cnt_q <= cnt_q + 4'h1;
				end
				if (addr_done & ~addr_ok)
					state_q <= S_IDLE;
				else if (addr_done | rx_done) begin
					state_q <= S_ACK;
					next_tx_q <= addr_done & byte_in[0];
				end
			end
			S_ACK: begin
				if (scl_fall) begin
					ack_on_q <= ~ack_on_q;
					if (ack_on_q) begin
						cnt_q <= 4'h0;
						state_q <= next_tx_q ? S_LOAD : S_RX;
					end
				end
			end
			S_LOAD: begin
				if (tx_load) begin
					sh_q <= tx_data_reg_q;
					cnt_q <= 4'h0;
					state_q <= S_TX;
				end
			end
			S_TX: begin
				if (scl_rise)
					cnt_q <= cnt_q + 4'h1;
				if (scl_fall) begin
					if (cnt_q == `DSF_BYTE_BITS)
						state_q <= S_TXACK;
					else
						sh_q <= {sh_q[6:0], 1'b0};
				end
			end
			S_TXACK: begin
				if (scl_rise)
					cnt_q <= `DSF_BYTE_BITS + 4'h1;
				if (nack_seen)
					state_q <= S_IDLE;
				else if (enter_load)
					state_q <= S_LOAD;
			end
			default: state_q <= S_IDLE;
			endcase
		end
	end

	// Line drivers are registered; one cycle of lag is far inside a link half period.
	always @(posedge SYS_CLK) begin
		if (RST) begin
			sda_oe_n_q <= 1'b1;
			scl_oe_n_q <= 1'b1;
		end else begin
			sda_oe_n_q <= ~(eng_on & (((state_q == S_ACK) & ack_on_q) |
				((state_q == S_TX) & ~sh_q[7])));
			// With no transmit data ready the clock is held low until software writes.
			scl_oe_n_q <= ~(eng_on & (state_q == S_LOAD) & tx_buf_empty_q);
		end
	end

	assign SDA_OUT = 1'b0;
	assign SCL_OUT = 1'b0;
	assign SDA_OE_N = sda_oe_n_q;
	assign SCL_OE_N = scl_oe_n_q;

	// Flag register. Hardware sets win over a clear in the same cycle.
	always @(posedge SYS_CLK) begin
		if (RST) begin
			{rx_irq_flag_q, tx_irq_flag_q, match_q, slave_dir_flag_q, ack_seen_n_q,
				clk_fall_flag_q, tx_buf_empty_q, rx_buf_full_q} <= `DSF_STATUS_RST;
			rx_data_reg_q <= `DSF_RX_DATA_RST;
		end else if (~module_on) begin
			rx_irq_flag_q <= 1'b0;
			tx_irq_flag_q <= 1'b0;
			clk_fall_flag_q <= 1'b0;
			match_q <= 1'b0;
			tx_buf_empty_q <= 1'b1;
			rx_buf_full_q <= 1'b0;
			slave_dir_flag_q <= one_way_mode_on;
		end else begin
			// Writing one to a flag keeps it; only zeros clear.
			if (rx_load)
				rx_irq_flag_q <= 1'b1;
			else if (wr_status & ~wbyte[`DSF_ST_RX_IRQ])
				rx_irq_flag_q <= 1'b0;
			if (enter_load)
				tx_irq_flag_q <= 1'b1;
			else if (wr_status & ~wbyte[`DSF_ST_TX_IRQ])
				tx_irq_flag_q <= 1'b0;
			if (clk_fall_ev)
				clk_fall_flag_q <= 1'b1;
			else if (~one_way_mode_on | (wr_status & ~wbyte[`DSF_ST_CLK_FALL]))
				clk_fall_flag_q <= 1'b0;
			if (addr_ok)
				match_q <= 1'b1;
			else if (rx_done & ~rx_buf_full_q)
				match_q <= 1'b0;
			if (one_way_mode_on)
				slave_dir_flag_q <= 1'b1;
			else if (addr_ok)
				slave_dir_flag_q <= byte_in[0];
			if (eng_on & (state_q == S_TXACK) & scl_rise)
				ack_seen_n_q <= sda_s;
			if (tx_load)
				tx_buf_empty_q <= 1'b1;
			else if (wr_tx_data)
				tx_buf_empty_q <= 1'b0;
			if (rx_load) begin
				rx_buf_full_q <= 1'b1;
				rx_data_reg_q <= byte_in;
			end else if (rd_rx_data)
				rx_buf_full_q <= 1'b0;
		end
	end

	// Sticky interrupt causes; a read of the cause register clears them.
	wire [4:0] irq_ev = {nack_seen, clk_fall_ev, addr_ok, enter_load, rx_load};

	always @(posedge SYS_CLK) begin
		if (RST)
			irq_st_q <= `DSF_IRQ_RST;
		else if (rd_irq_st)
			irq_st_q <= irq_ev;
		else
			irq_st_q <= irq_st_q | irq_ev;
	end

	assign IRQ = |(irq_st_q & irq_mask_q);
endmodule

// File: hdl/dsf_map.vh
`ifndef DSF_MAP_VH
`define DSF_MAP_VH

// Word indices on the register bus; the byte address is four times the index.
`define DSF_IDX_CTRL 6'h16
`define DSF_IDX_OWN_ADDR 6'h17
`define DSF_IDX_EXT_ADDR 6'h18
`define DSF_IDX_STATUS 6'h19
`define DSF_IDX_TX_DATA 6'h1a
`define DSF_IDX_RX_DATA 6'h1b
`define DSF_IDX_IRQ_STATUS 6'h1c
`define DSF_IDX_IRQ_MASK 6'h1d

// Flag status register bit positions.
`define DSF_ST_RX_IRQ 7
`define DSF_ST_TX_IRQ 6
`define DSF_ST_MATCH 5
`define DSF_ST_SLAVE_DIR 4
`define DSF_ST_ACK_SEEN_N 3
`define DSF_ST_CLK_FALL 2
`define DSF_ST_TX_EMPTY 1
`define DSF_ST_RX_FULL 0

// Control register bit positions.
`define DSF_CTRL_MODULE_ON 0
`define DSF_CTRL_ONE_WAY 1
`define DSF_CTRL_EXT_ADDR 2

// Interrupt status and mask bit positions.
`define DSF_IRQ_RX 0
`define DSF_IRQ_TX 1
`define DSF_IRQ_MATCH 2
`define DSF_IRQ_CLK_FALL 3
`define DSF_IRQ_NACK 4

// Reset values.
`define DSF_STATUS_RST 8'h0a
`define DSF_TX_DATA_RST 8'hff
`define DSF_RX_DATA_RST 8'h00
`define DSF_CTRL_RST 3'h0
`define DSF_ADDR_RST 7'h00
`define DSF_IRQ_RST 5'h00

// Bits in one serial byte.
`define DSF_BYTE_BITS 4'h8

`endif

// File: hdl/dsf_sync.v
`timescale 1ns/100ps
module dsf_sync #(
	parameter W = 2
) (
	input wire clk,
	input wire rst,
	input wire [W-1:0] din,
	output wire [W-1:0] dout
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// Idle level of an open-drain line is high, so the chain resets to ones.
	always @(posedge clk) begin
		if (rst) begin
			meta_q <= {W{1'b1}};
			sync_q <= {W{1'b1}};
		end else begin
			meta_q <= din;
			sync_q <= meta_q;
		end
	end

	assign dout = sync_q;
endmodule

// File: hdl/dsf_cond.v
`timescale 1ns/100ps
module dsf_cond (
	input wire clk,
	input wire rst,
	input wire scl,
	input wire sda,
	output wire scl_rise,
	output wire scl_fall,
	output wire bus_start,
	output wire bus_stop
);
	reg scl_q;
	reg sda_q;

	always @(posedge clk) begin
		if (rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	assign scl_rise = scl & ~scl_q;
	assign scl_fall = ~scl & scl_q;
	// A data edge while the clock stays high marks a start or a stop.
	assign bus_start = scl & scl_q & sda_q & ~sda;
	assign bus_stop = scl & scl_q & ~sda_q & sda;
endmodule

// File: verification/dsf_top_chk.sv
`timescale 1ns/100ps
module dsf_top_chk (
	input wire SYS_CLK,
	input wire RST,
	input wire [7:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire [31:0] AVS_READDATA,
	input wire AVS_WAITREQUEST,
	input wire IRQ,
	input wire SCL_IN,
	input wire SCL_OE_N,
	input wire SDA_OE_N
);
	logic [2:0] ctl_q;
	logic [4:0] msk_q;
	wire wr_done = AVS_WRITE && !AVS_WAITREQUEST;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	// Shadow copies of control and mask, so that flag checks can follow the mode.
	always @(posedge SYS_CLK) begin
		if (RST) begin
			ctl_q <= 3'h0;
			msk_q <= 5'h00;
		end else if (wr_done && AVS_ADDRESS[7:2] == 6'h16) begin
			ctl_q <= AVS_WRITEDATA[2:0];
		end else if (wr_done && AVS_ADDRESS[7:2] == 6'h1d) begin
			msk_q <= AVS_WRITEDATA[4:0];
		end
	end
	sequence s_rd;
		AVS_READ && !AVS_WAITREQUEST;
	endsequence
	sequence s_st_rd;
		s_rd ##0 AVS_ADDRESS[7:2] == 6'h19;
	endsequence
	chk_reset_quiet: assert property (disable iff (1'b0) RST |=> !IRQ && SDA_OE_N && SCL_OE_N)
		else $error("outputs active after reset");
	chk_rd_upper: assert property (s_rd |-> AVS_READDATA[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_wait_once: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("more than one wait cycle");
	chk_off_flags: assert property (s_st_rd ##0 !ctl_q[0] |-> (AVS_READDATA[7:0] & 8'he7) == 8'h02)
		else $error("flags wrong while module off");
	chk_oneway_dir: assert property (s_st_rd ##0 ctl_q[1:0] == 2'b11 |-> AVS_READDATA[4])
		else $error("direction not forced in one-way mode");
	chk_fall_irq: assert property ($fell(SCL_IN) && ctl_q[1:0] == 2'b11 && msk_q[3] |-> ##[1:6] IRQ)
		else $error("clock fall raised no interrupt");
	chk_irq_masked: assert property (msk_q == 5'h00 |-> !IRQ)
		else $error("interrupt with all masked");
	chk_stretch_on: assert property (!SCL_OE_N |-> ctl_q[0] || $past(ctl_q[0]))
		else $error("clock held while module off");
	chk_sda_off: assert property (!ctl_q[0] [*3] |-> SDA_OE_N)
		else $error("data line driven while module off");
endmodule
bind dsf_top dsf_top_chk u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ),
	.SCL_IN(SCL_IN), .SCL_OE_N(SCL_OE_N), .SDA_OE_N(SDA_OE_N));

// File: verification/dsf_host.sv
`timescale 1ns/100ps
module dsf_host (
	input wire dev_scl_oe_n,
	input wire dev_sda_oe_n,
	output wire scl,
	output wire sda
);
	logic m_scl = 1'b1;
	logic m_sda = 1'b1;
	// Both lines have pull-ups, so a released line reads high.
	assign scl = m_scl & dev_scl_oe_n;
	assign sda = m_sda & dev_sda_oe_n;
	task automatic clk_bit(input logic b, output logic r);
		int n;
		m_sda = b;
		#12;
		m_scl = 1'b1;
		n = 0;
		// The slave may stretch the clock while it waits for transmit data.
		while (!scl && n < 400) begin
			#5;
			n++;
		end
		#12;
		r = sda;
		#12;
		m_scl = 1'b0;
		#12;
	endtask
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], q[i]);
		clk_bit(a, k);
	endtask
	task start();
		m_sda = 1'b1;
		m_scl = 1'b1;
		#24;
		m_sda = 1'b0;
		#24;
		m_scl = 1'b0;
		#12;
	endtask
	task stop();
		m_sda = 1'b0;
		#12;
		m_scl = 1'b1;
		#24;
		m_sda = 1'b1;
		#24;
	endtask
	task pulse();
		m_scl = 1'b0;
		#24;
		m_scl = 1'b1;
		#24;
	endtask
endmodule

// File: verification/dsf_top_tb.sv
`timescale 1ns/100ps
module dsf_top_tb;
	logic SYS_CLK = 1'b0;
	logic RST = 1'b1;
	logic [7:0] AVS_ADDRESS = 8'h00;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0;
	wire [31:0] AVS_READDATA;
	wire AVS_WAITREQUEST, IRQ, SCL_OE_N, SDA_OE_N, scl, sda;
	int n_mismatch = 0;
	int comparisons = 0;
	logic [15:0] exp_q[$];
	logic [15:0] v;
	logic [6:0] own;
	logic [7:0] d1, d2, q;
	logic k;
	always #2.5 SYS_CLK = ~SYS_CLK;
	dsf_top u_dsf_top (.SYS_CLK(SYS_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(4'hf),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ), .SCL_IN(scl), .SCL_OUT(),
		.SCL_OE_N(SCL_OE_N), .SDA_IN(sda), .SDA_OUT(), .SDA_OE_N(SDA_OE_N));
	dsf_host u_host (.dev_scl_oe_n(SCL_OE_N), .dev_sda_oe_n(SDA_OE_N), .scl(scl), .sda(sda));
	task check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task bus(input logic w, input logic [5:0] i, input logic [7:0] d);
		int n;
		@(posedge SYS_CLK);
		AVS_ADDRESS <= {i, 2'b00};
		AVS_WRITEDATA <= {24'h0, d};
		AVS_READ <= !w;
		AVS_WRITE <= w;
		n = 0;
		// The request stands until the rising edge at which waitrequest is seen low.
		do begin
			@(posedge SYS_CLK);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
		if (AVS_WAITREQUEST !== 1'b0) begin
			n_mismatch++;
			complete_run();
		end
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask
	task wr(input logic [5:0] i, input logic [7:0] d);
		bus(1'b1, i, d);
	endtask
	task rd(input logic [5:0] i, input logic [7:0] m, input logic [7:0] e);
		exp_q.push_back({m, e & m});
		bus(1'b0, i, 8'h00);
	endtask
	task ck_irq(input logic e);
		@(negedge SYS_CLK);
		check({7'h0, IRQ}, {7'h0, e});
	endtask
	// Each completed read is matched with the oldest expectation noted for it.
	always @(posedge SYS_CLK) begin
		if (AVS_READ && AVS_WAITREQUEST === 1'b0 && exp_q.size() > 0) begin
			v = exp_q.pop_front();
			check(AVS_READDATA[7:0] & v[15:8], v[7:0]);
		end
	end
	initial begin
		#400000;
		n_mismatch++;
		complete_run();
	end
	initial begin
		void'($urandom(43007));
		repeat (2) @(posedge SYS_CLK);
		RST <= 1'b0;
		own = 7'($urandom);
		d1 = 8'($urandom);
		d2 = 8'($urandom);
		rd(6'h19, 8'hff, 8'h0a);
		wr(6'h19, 8'h00);
		rd(6'h19, 8'hff, 8'h0a);
		rd(6'h3f, 8'hff, 8'h00);
		$display("test reset done");
		wr(6'h17, {1'b0, own});
		wr(6'h1d, 8'h1f);
		wr(6'h16, 8'h01);
		u_host.start();
		u_host.xfer({own, 1'b0}, 1'b1, q, k);
		check({7'h0, k}, 8'h00);
		rd(6'h19, 8'hb1, 8'ha1);
		ck_irq(1'b1);
		rd(6'h1b, 8'hff, {own, 1'b0});
		u_host.xfer(d1, 1'b1, q, k);
		u_host.xfer(d2, 1'b1, q, k);
		rd(6'h19, 8'h21, 8'h01);
		rd(6'h1b, 8'hff, d1);
		rd(6'h19, 8'h01, 8'h00);
		u_host.stop();
		wr(6'h19, 8'hff);
		rd(6'h19, 8'h80, 8'h80);
		wr(6'h19, 8'h7f);
		rd(6'h19, 8'h80, 8'h00);
		wr(6'h1d, 8'h00);
		ck_irq(1'b0);
		wr(6'h1d, 8'h1f);
		ck_irq(1'b1);
		rd(6'h1c, 8'h01, 8'h01);
		ck_irq(1'b0);
		$display("test receive done");
		wr(6'h18, {1'b0, ~own});
		wr(6'h16, 8'h05);
		wr(6'h1a, d1);
		rd(6'h19, 8'h02, 8'h00);
		u_host.start();
		u_host.xfer({~own, 1'b1}, 1'b1, q, k);
		check({7'h0, k}, 8'h00);
		u_host.xfer(8'hff, 1'b0, q, k);
		check(q, d1);
		// No second byte is written yet, so the slave must stretch the clock.
		rd(6'h19, 8'h5a, 8'h52);
		@(negedge SYS_CLK);
		check({7'h0, SCL_OE_N}, 8'h00);
		wr(6'h1a, d2);
		u_host.xfer(8'hff, 1'b1, q, k);
		check(q, d2);
		check({7'h0, sda}, 8'h01);
		u_host.stop();
		rd(6'h19, 8'h0a, 8'h0a);
		$display("test transmit done");
		wr(6'h16, 8'h03);
		rd(6'h19, 8'h10, 8'h10);
		rd(6'h1c, 8'h1f, 8'h17);
		ck_irq(1'b0);
		u_host.pulse();
		ck_irq(1'b1);
		rd(6'h19, 8'h04, 8'h04);
		wr(6'h19, 8'hfb);
		rd(6'h19, 8'h04, 8'h00);
		u_host.pulse();
		wr(6'h16, 8'h01);
		rd(6'h19, 8'h04, 8'h00);
		wr(6'h16, 8'h00);
		rd(6'h19, 8'he7, 8'h02);
		$display("test one-way done");
		complete_run();
	end
endmodule
